// [hdl/ilml_chan.sv]
`timescale 1ns/100ps
// Per-channel peak hold, overflow grade and zero-cross detector
module ilml_chan
   import ilml_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        sample_valid,
   input  wire logic [15:0] sample,
   input  wire logic        hold_clr,
   input  wire logic        peak_rd_clr,
   input  wire logic        ovf_rd_clr,
   output logic      [14:0] peak,
   output logic      [2:0]  ovf_level,
   output logic      [15:0] mag,
   output logic             zero_cross
);
   logic        prev_sign;
   logic [15:0] raw_abs;
   logic [14:0] mag_sat;
   logic [14:0] peak_base;
   logic [2:0]  ovf_base;
   logic [2:0]  grade;

   // Full-scale negative saturates so the high byte stays 7f
   assign raw_abs    = sample[15] ? 16'(-sample) : sample;
   assign mag_sat    = raw_abs[15] ? 15'h7fff : raw_abs[14:0];
   assign mag        = {1'b0, mag_sat};
   assign zero_cross = sample_valid & (sample[15] != prev_sign);
   assign grade      = (mag >= OVF_M0P00)  ? 3'h6 :
                       (mag >= OVF_M1P80)  ? 3'h5 :
                       (mag >= OVF_M4P08)  ? 3'h4 :
                       (mag >= OVF_M6P02)  ? 3'h3 :
                       (mag >= OVF_M8P52)  ? 3'h2 :
                       (mag >= OVF_M12P04) ? 3'h1 : 3'h0;
   // A sample in the clearing cycle still lands
   assign peak_base  = peak_rd_clr ? 15'h0000 : peak;
   assign ovf_base   = ovf_rd_clr ? 3'h0 : ovf_level;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         peak      <= 15'h0000;
         ovf_level <= 3'h0;
         prev_sign <= 1'b0;
      end else if (hold_clr) begin
         peak      <= 15'h0000; // [R3]
         ovf_level <= 3'h0; // [R11]
         prev_sign <= 1'b0;
      end else begin
         if (sample_valid) begin
            prev_sign <= sample[15];
         end
         if (sample_valid && mag_sat > peak_base) begin
            peak <= mag_sat; // [R26]
         end else begin
            peak <= peak_base; // [R2]
         end
         if (sample_valid && grade > ovf_base) begin
            ovf_level <= grade; // [R10]
         end else begin
            ovf_level <= ovf_base; // [R11]
         end
      end
   end
endmodule // ilml_chan

// [hdl/ilml_pkg.sv]
package ilml_pkg;
   // ****************************************************
   // Register indices, byte address is four times these
   // ****************************************************
   localparam logic [9:0] IDX_PEAK_LO_L  = 10'h004;
   localparam logic [9:0] IDX_PEAK_HI_L  = 10'h005;
   localparam logic [9:0] IDX_PEAK_LO_R  = 10'h006;
   localparam logic [9:0] IDX_PEAK_HI_R  = 10'h007;
   localparam logic [9:0] IDX_STATUS     = 10'h008;
   localparam logic [9:0] IDX_LIM_CTRL   = 10'h009;
   localparam logic [9:0] IDX_GAIN_L     = 10'h00a;
   localparam logic [9:0] IDX_GAIN_R     = 10'h00b;
   localparam logic [9:0] IDX_CONFIG     = 10'h010;

   // ****************************************************
   // Reset values
   // ****************************************************
   localparam logic [7:0] LIM_CTRL_RST   = 8'h18;
   localparam logic [6:0] CONFIG_RST     = 7'h63;
   localparam logic [6:0] GAIN_RST       = 7'h30;

   // ****************************************************
   // Field positions
   // ****************************************************
   localparam int LC_EN     = 7;
   localparam int LC_RCV    = 6;
   localparam int LC_THR    = 3;
   localparam int CF_PM0    = 0;
   localparam int CF_PM1    = 1;
   localparam int CF_WRITE_ZERO_CROSS_EN   = 2;
   localparam int CF_LIMITER_ZERO_CROSS_EN   = 3;
   localparam int CF_LTM    = 4;
   localparam int CF_COMMON = 6;

   // ****************************************************
   // Magnitude thresholds of a 16-bit sample
   // ****************************************************
   localparam logic [15:0] OVF_M12P04 = 16'h2000;
   localparam logic [15:0] OVF_M8P52  = 16'h3000;
   localparam logic [15:0] OVF_M6P02  = 16'h4000;
   localparam logic [15:0] OVF_M4P08  = 16'h5000;
   localparam logic [15:0] OVF_M1P80  = 16'h6800;
   localparam logic [15:0] OVF_M0P00  = 16'h7fff;
   localparam logic [15:0] LIM_M8     = 16'h32f5;
   localparam logic [15:0] LIM_M6     = 16'h4027;
   localparam logic [15:0] LIM_M4     = 16'h50c3;
   localparam logic [15:0] LIM_M2     = 16'h65ad;

   // ****************************************************
   // Timing, in sample periods or clock cycles, and the gain ceiling
   // ****************************************************
   localparam logic [10:0] LIM_TMO_BASE  = 11'd129;
   localparam logic [11:0] WR_TMO        = 12'd2049;
   localparam logic [7:0]  INIT_CYCLES   = 8'd64;
   localparam logic [6:0]  GAIN_MAX      = 7'h68;

   typedef enum logic [1:0] {
      ILML_LIM_IDLE   = 2'b00,
      ILML_LIM_ACTIVE = 2'b01
   } ilml_lim_e;
endpackage

// [hdl/ilml_top.sv]
// Design decision made here: the APB register port.
`timescale 1ns/100ps
// Function
// [R1] Separate absolute peaks per channel; high byte sign bit reads zero.
// [R2] Reading a peak high byte clears that channel; read low byte first.
// [R3] Peaks clear while power-down pin low or ADC power off.
// [R4] Zero-cross host write drops channel flag until gain really changes.
// [R5] Rewrite of a waiting channel keeps the running timeout count.
// [R6] Write to a done channel while other waits restarts the timeout.
// [R7] Flags read one when zero-cross off or any limiter mode.
// [R8] Flags read zero during init after power-down release, then one.
// [R9] Flags zero while power-down pin low; one when input stage off.
// [R10] Three-bit overflow grade per channel holds the maximum seen.
// [R11] Status read clears overflow grades; also power-down and ADC off.
// [R12] Input over threshold lowers the shared gain by step count.
// [R13] Limiter zero-cross bit picks zero-cross wait or fixed period.
// [R14] Attenuation repeats while over threshold, from current gain.
// [R15] Idle flag rises when attenuation ends, falls on new overrun.
// [R16] Host gain writes ignored during attenuation, applied when idle.
// [R17] Bit 7 limiter enable, bit 6 recovery, recovery needs limiter.
// [R18] Host passes through manual mode between automatic modes.
// [R19] Host equalises gains first and writes both in semi-auto mode.
// [R20] Threshold field selects -8, -6, -4 or -2 dB detection.
// [R21] Step is field plus one; result clips at mute code zero.
// [R22] Limiter control resets to 18, held and locked at power-down.
// [R23] Write zero-cross enable: per-channel wait, else immediate change.
// [R24] Timing field gives 129..1032 timeout or 1..8 period.
// [R25] Gain is seven-bit code from mute up to 68; host writes above 68 are stored unclipped.
// [R26] Every sample magnitude larger than the stored peak replaces it.
module ilml_top
   import ilml_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        power_down_pin_n,
   input  wire logic        sample_valid,
   input  wire logic [15:0] left_sample,
   input  wire logic [15:0] right_sample,
   output logic      [6:0]  left_gain_code,
   output logic      [6:0]  right_gain_code,
   output logic             limiter_idle_flag
);
   // ****************************************************
   // Power-down pin synchroniser and init timer
   // ****************************************************
   logic       pd_meta;
   logic       pd_sync;
   logic [7:0] init_cnt;
   logic       init_busy;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pd_meta <= 1'b0;
         pd_sync <= 1'b0;
      end else begin
         pd_meta <= power_down_pin_n;
         pd_sync <= pd_meta;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         init_cnt <= 8'h00;
      end else if (!pd_sync) begin
         init_cnt <= 8'h00;
      end else if (init_busy) begin
         init_cnt <= init_cnt + 8'h01;
      end
   end
   assign init_busy = init_cnt != INIT_CYCLES;

   // ****************************************************
   // APB decode
   // ****************************************************
   logic [9:0] idx;
   logic       acc;
   logic       wr;
   logic       rd;
   logic       mapped;
   logic       setup;

   assign idx    = paddr[11:2];
   assign setup  = psel & ~penable;
   assign acc    = psel & penable & pready;
   assign wr     = acc & pwrite;
   assign rd     = acc & ~pwrite;
   assign mapped = (idx >= IDX_PEAK_LO_L && idx <= IDX_GAIN_R) || idx == IDX_CONFIG;

   // ****************************************************
   // Control registers
   // ****************************************************
   logic [7:0] lim_ctrl;
   logic [6:0] cfg;
   logic       lim_en;
   logic       pm0;
   logic       pm1;
   logic       write_zero_cross_en;
   logic       limiter_zero_cross_en;
   logic [1:0] ltm;
   logic       common;

   assign lim_en = lim_ctrl[LC_EN];
   assign pm0    = cfg[CF_PM0];
   assign pm1    = cfg[CF_PM1];
   assign write_zero_cross_en   = cfg[CF_WRITE_ZERO_CROSS_EN];
   assign limiter_zero_cross_en   = cfg[CF_LIMITER_ZERO_CROSS_EN];
   assign ltm    = cfg[CF_LTM +: 2];
   assign common = cfg[CF_COMMON];

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lim_ctrl <= LIM_CTRL_RST;
         cfg      <= CONFIG_RST;
      end else if (!pd_sync) begin
         lim_ctrl <= LIM_CTRL_RST; // [R22]
         cfg      <= CONFIG_RST;
      end else begin
         if (wr && idx == IDX_LIM_CTRL) begin
            // Recovery bit cannot stand without the limiter
            lim_ctrl <= {pwdata[7], pwdata[6] & pwdata[7], 1'b0, pwdata[4:0]}; // [R17]
         end
         if (wr && idx == IDX_CONFIG) begin
            cfg <= pwdata[6:0];
         end
      end
   end

   // ****************************************************
   // Channels
   // ****************************************************
   logic [15:0] samp [2];
   logic [14:0] peak [2];
   logic [2:0]  ovf  [2];
   logic [15:0] mag  [2];
   logic [1:0]  zc;
   logic [1:0]  peak_clr;
   logic        hold_clr;
   logic        ovf_clr;

   assign samp[0]     = left_sample;
   assign samp[1]     = right_sample;
   assign hold_clr    = ~pd_sync | ~pm1;
   assign ovf_clr     = rd & (idx == IDX_STATUS); // [R11]
   assign peak_clr[0] = rd & (idx == IDX_PEAK_HI_L); // [R2]
   assign peak_clr[1] = rd & (idx == IDX_PEAK_HI_R); // [R2]

   // ****************************************************
   // Limiter timing and attenuation
   // ****************************************************
   logic [15:0] thr;
   logic        exceed;
   logic [10:0] lim_cnt;
   logic [10:0] lim_tmo;
   logic [10:0] lim_per;
   logic        lim_due;
   logic        lim_seen;
   logic        lim_apply;
   logic        lim_finish;
   logic [6:0]  gain [2];
   logic [6:0]  gain_min;
   logic [3:0]  step;
   logic [6:0]  att;
   ilml_lim_e   lim_state;

   assign thr = (lim_ctrl[LC_THR +: 2] == 2'b00) ? LIM_M8 :
                (lim_ctrl[LC_THR +: 2] == 2'b01) ? LIM_M6 :
                (lim_ctrl[LC_THR +: 2] == 2'b10) ? LIM_M4 : LIM_M2; // [R20]
   assign exceed  = sample_valid & (mag[0] >= thr | mag[1] >= thr);
   assign lim_tmo = LIM_TMO_BASE << ltm; // [R24]
   assign lim_per = 11'd1 << ltm; // [R24]
   assign lim_due = sample_valid & (limiter_zero_cross_en ? ((|zc) | (lim_cnt + 11'd1 >= lim_tmo))
                                         : (lim_cnt + 11'd1 >= lim_per)); // [R13]
   assign lim_apply  = lim_state == ILML_LIM_ACTIVE & lim_due & (lim_seen | exceed); // [R14]
   assign lim_finish = lim_state == ILML_LIM_ACTIVE & lim_due & ~(lim_seen | exceed);
   assign gain_min   = (gain[0] < gain[1]) ? gain[0] : gain[1];
   assign step       = {1'b0, lim_ctrl[2:0]} + 4'h1; // [R21]
   assign att        = ({3'h0, step} >= gain_min) ? 7'h00 : gain_min - {3'h0, step}; // [R21]

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         lim_state <= ILML_LIM_IDLE;
         lim_cnt   <= 11'h000;
         lim_seen  <= 1'b0;
      end else if (!pd_sync || !pm0 || !lim_en) begin
         lim_state <= ILML_LIM_IDLE;
         lim_cnt   <= 11'h000;
         lim_seen  <= 1'b0;
      end else begin
         case (lim_state)
            ILML_LIM_IDLE: begin
               if (exceed) begin
                  lim_state <= ILML_LIM_ACTIVE; // [R15]
                  lim_seen  <= 1'b1;
                  lim_cnt   <= 11'h000;
               end
            end
            ILML_LIM_ACTIVE: begin
               if (lim_due) begin
                  lim_cnt  <= 11'h000;
                  lim_seen <= 1'b0;
                  if (lim_finish) begin
                     lim_state <= ILML_LIM_IDLE; // [R15]
                  end
               end else if (sample_valid) begin
                  lim_cnt  <= lim_cnt + 11'd1;
                  lim_seen <= lim_seen | exceed; // [R14]
               end
            end
            default: begin
               lim_state <= ILML_LIM_IDLE;
            end
         endcase
      end
   end

   // ****************************************************
   // Gain registers and host zero-cross updating
   // ****************************************************
   logic [1:0]  host_wr;
   logic [1:0]  pend;
   logic [1:0]  zf;
   logic [6:0]  target [2];
   logic [11:0] wr_cnt;
   logic        wr_tmo;
   logic        host_ok;
   logic        zc_mode;
   logic        wr_restart;

   // Writes during attenuation are dropped, not queued
   assign host_ok    = ~lim_en | (lim_state == ILML_LIM_IDLE); // [R16]
   assign host_wr[0] = wr & host_ok & (idx == IDX_GAIN_L);
   assign host_wr[1] = wr & host_ok & (idx == IDX_GAIN_R | (idx == IDX_GAIN_L & common));
   assign zc_mode    = write_zero_cross_en & ~lim_en; // [R23]
   assign wr_restart = zc_mode & |(host_wr & ~pend); // [R6]
   assign wr_tmo     = sample_valid & (|pend) & (wr_cnt + 12'd1 >= WR_TMO);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wr_cnt <= 12'h000;
      end else if (wr_restart || !(|pend)) begin
         wr_cnt <= 12'h000;
      end else if (sample_valid) begin
         wr_cnt <= wr_cnt + 12'd1; // [R5]
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         ilml_chan u_chan (
            .clk_sys      (clk_sys),
            .sys_rst      (sys_rst),
            .sample_valid (sample_valid),
            .sample       (samp[g]),
            .hold_clr     (hold_clr),
            .peak_rd_clr  (peak_clr[g]),
            .ovf_rd_clr   (ovf_clr),
            .peak         (peak[g]),
            .ovf_level    (ovf[g]),
            .mag          (mag[g]),
            .zero_cross   (zc[g])
         );

         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               gain[g]   <= GAIN_RST;
               target[g] <= GAIN_RST;
               pend[g]   <= 1'b0;
            end else if (!pd_sync || !pm0) begin
               gain[g]   <= GAIN_RST;
               target[g] <= GAIN_RST;
               pend[g]   <= 1'b0;
            end else if (lim_apply) begin
               gain[g]   <= att; // [R12]
               pend[g]   <= 1'b0;
            end else if (host_wr[g] && zc_mode) begin
               target[g] <= pwdata[6:0]; // [R25]
               pend[g]   <= 1'b1; // [R4]
            end else if (host_wr[g]) begin
               gain[g]   <= pwdata[6:0]; // [R16]
               pend[g]   <= 1'b0;
            end else if (pend[g] && (zc[g] || wr_tmo || !zc_mode)) begin
               gain[g]   <= target[g]; // [R4]
               pend[g]   <= 1'b0;
            end
         end

         // Init and pin low win over the forced-one cases
         assign zf[g] = ~pd_sync | init_busy ? 1'b0 : // [R8] [R9]
                        (~write_zero_cross_en | lim_en | ~pm0) ? 1'b1 : ~pend[g]; // [R7]
      end
   endgenerate

   // ****************************************************
   // Read mux and registered APB answer
   // ****************************************************
   logic [7:0] rmux;
   logic       idle_now;

   assign idle_now = lim_state == ILML_LIM_IDLE;
   assign rmux = (idx == IDX_PEAK_LO_L) ? peak[0][7:0] :
                 (idx == IDX_PEAK_HI_L) ? {1'b0, peak[0][14:8]} : // [R1]
                 (idx == IDX_PEAK_LO_R) ? peak[1][7:0] :
                 (idx == IDX_PEAK_HI_R) ? {1'b0, peak[1][14:8]} : // [R1]
                 (idx == IDX_STATUS)    ? {zf[1], zf[0], ovf[1], ovf[0]} :
                 (idx == IDX_LIM_CTRL)  ? lim_ctrl :
                 (idx == IDX_GAIN_L)    ? {idle_now, gain[0]} :
                 (idx == IDX_GAIN_R)    ? {idle_now, gain[1]} :
                 (idx == IDX_CONFIG)    ? {1'b0, cfg} : 8'h00;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= ~mapped;
         prdata  <= {24'h00_0000, pwrite ? 8'h00 : rmux};
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         left_gain_code    <= GAIN_RST;
         right_gain_code   <= GAIN_RST;
         limiter_idle_flag <= 1'b1;
      end else begin
         left_gain_code    <= gain[0];
         right_gain_code   <= gain[1];
         limiter_idle_flag <= idle_now; // [R15]
      end
   end

   // ****************************************************
   // Assertions
   // ****************************************************
   AST_PEAK_SIGN: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R1]
      rd && idx == IDX_PEAK_HI_L |-> prdata[7:0] == {1'b0, $past(peak[0][14:8])})
      else $error("peak high byte sign bit set");
   AST_PEAK_CLR: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R2]
      peak_clr[0] && !sample_valid |=> peak[0] == 15'h0000)
      else $error("left peak not cleared by high byte read");
   AST_PEAK_PD: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R3]
      hold_clr |=> peak[0] == 15'h0000 && peak[1] == 15'h0000)
      else $error("peak not cleared in power-down");
   AST_OVF_CLR: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R11]
      ovf_clr && !sample_valid |=> ovf[0] == 3'h0 && ovf[1] == 3'h0)
      else $error("overflow grade survived status read");
   AST_ZF_FORCE: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R7]
      pd_sync && !init_busy && lim_en |-> zf == 2'b11)
      else $error("flags not forced in limiter mode");
   AST_ZF_PD: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R9]
      !pd_sync |-> zf == 2'b00)
      else $error("flags not zero with pin low");
   AST_LIM_STEP: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R12]
      lim_apply && pd_sync && pm0 |=> gain[0] == $past(att) && gain[1] == gain[0])
      else $error("limiter step not applied to both channels");
   AST_HOST_IGN: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R16]
      wr && idx == IDX_GAIN_L && lim_en && !idle_now && !lim_apply && pd_sync && pm0
      |=> gain[0] == $past(gain[0]))
      else $error("host gain write not ignored");
   AST_LC_PD: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R22]
      !pd_sync |=> lim_ctrl == LIM_CTRL_RST)
      else $error("limiter control not held at reset");
   AST_RCV_MASK: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R17]
      lim_ctrl[LC_RCV] |-> lim_ctrl[LC_EN])
      else $error("recovery on without limiter");
endmodule // ilml_top

// [verification/ilml_host.sv]
`timescale 1ns/100ps
// ****************************************************
// Host side of the register port
// ****************************************************
module ilml_host
   import ilml_pkg::*;
(
   input  wire logic        clk_sys,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [11:0] paddr,
   output logic      [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
   end

   // Call right after a rising edge; the request holds until pready is seen or 16 edges pass
   task automatic xfer(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err, output logic hung);
      int n = 0;
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= {idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      hung = (pready !== 1'b1);
      rd   = prdata;
      err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Idle edge, so back-to-back calls never drive psel twice in one step
      @(posedge clk_sys);
   endtask
endmodule // ilml_host

// [verification/tb_input_level_monitor_limiter.sv]
`timescale 1ns/100ps
module tb_input_level_monitor_limiter;
   import ilml_pkg::*;
   logic        clk_sys = 1'b0, sys_rst = 1'b1, power_down_pin_n = 1'b0;
   logic        sample_valid = 1'b0, psel, penable, pwrite, pready, pslverr;
   logic [15:0] left_sample = 16'h0000, right_sample = 16'h0000;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [6:0]  left_gain_code, right_gain_code;
   logic        limiter_idle_flag, err, hung;
   int          mismatches = 0, n_compared = 0;

   always #5 clk_sys = ~clk_sys;

   ilml_top i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .power_down_pin_n(power_down_pin_n), .sample_valid(sample_valid),
      .left_sample(left_sample), .right_sample(right_sample),
      .left_gain_code(left_gain_code), .right_gain_code(right_gain_code),
      .limiter_idle_flag(limiter_idle_flag));
   ilml_host i_host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   // ****************************************************
   // Shared tasks
   // ****************************************************
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // A hung transfer ends the run at once
   task automatic acc(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      i_host.xfer(wr, idx, wd, rdv, err, hung);
      if (hung) begin
         mismatches++;
         print_verdict();
      end
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
      acc(1'b0, idx, 8'h00);
      check(rdv, {24'h00_0000, exp});
   endtask

   // n sample ticks, each followed by seven quiet cycles
   task automatic smp(input logic [15:0] l, input logic [15:0] r, input int n);
      repeat (n) begin
         sample_valid <= 1'b1;
         left_sample  <= l;
         right_sample <= r;
         @(posedge clk_sys);
         sample_valid <= 1'b0;
         repeat (7) @(posedge clk_sys);
      end
   endtask

   // ****************************************************
   // Scenarios
   // ****************************************************
   task automatic t_init();
      acc(1'b1, IDX_LIM_CTRL, 8'h9f);
      power_down_pin_n <= 1'b1;
      @(posedge clk_sys);
      rd_chk(IDX_STATUS, 8'h00);
      rd_chk(IDX_LIM_CTRL, 8'h18);
      repeat (80) @(posedge clk_sys);
      rd_chk(IDX_STATUS, 8'hc0);
      rd_chk(IDX_GAIN_L, 8'hb0);
      $display("init test done");
   endtask

   task automatic t_peak();
      smp(16'hedcc, 16'h0456, 1);
      smp(16'h0100, 16'hfff0, 1);
      rd_chk(IDX_PEAK_LO_L, 8'h34);
      rd_chk(IDX_PEAK_HI_L, 8'h12);
      rd_chk(IDX_PEAK_LO_L, 8'h00);
      rd_chk(IDX_PEAK_LO_R, 8'h56);
      rd_chk(IDX_PEAK_HI_R, 8'h04);
      smp(16'h8000, 16'h5000, 1);
      rd_chk(IDX_PEAK_LO_L, 8'hff);
      rd_chk(IDX_STATUS, 8'he6);
      rd_chk(IDX_STATUS, 8'hc0);
      acc(1'b1, IDX_CONFIG, 8'h61);
      rd_chk(IDX_PEAK_HI_L, 8'h00);
      acc(1'b1, IDX_CONFIG, 8'h67);
      acc(1'b1, IDX_GAIN_L, 8'h20);
      rd_chk(IDX_STATUS, 8'h00);
      smp(16'h0100, 16'h0100, 1);
      smp(16'hff00, 16'hff00, 2);
      rd_chk(IDX_STATUS, 8'hc0);
      check(32'(right_gain_code), 32'h20);
      acc(1'b1, IDX_CONFIG, 8'h63);
      $display("peak and zero-cross test done");
   endtask

   task automatic t_limit();
      acc(1'b0, 10'h001, 8'h00);
      check(rdv, 32'h0000_0000);
      check(32'(err), 32'h0000_0001);
      acc(1'b1, IDX_LIM_CTRL, 8'hff);
      rd_chk(IDX_LIM_CTRL, 8'hdf);
      acc(1'b1, IDX_LIM_CTRL, 8'h18);
      acc(1'b1, IDX_LIM_CTRL, 8'h9e);
      smp(16'h7000, 16'h0000, 4);
      check(32'(limiter_idle_flag), 32'h0);
      acc(1'b1, IDX_GAIN_L, 8'h30);
      smp(16'h7000, 16'h0000, 40);
      check(32'(left_gain_code), 32'h0);
      check(32'(right_gain_code), 32'h0);
      rd_chk(IDX_STATUS, 8'hc5);
      smp(16'h0000, 16'h0000, 8);
      check(32'(limiter_idle_flag), 32'h1);
      acc(1'b1, IDX_GAIN_L, 8'h10);
      repeat (4) @(posedge clk_sys);
      check(32'(right_gain_code), 32'h10);
      rd_chk(IDX_GAIN_L, 8'h90);
      $display("limiter test done");
   endtask

   // Shared host timeout runs 2049 samples; positive samples never cross zero
   task automatic t_zero_cross();
      acc(1'b1, IDX_LIM_CTRL, 8'h18);
      acc(1'b1, IDX_CONFIG, 8'h27);
      acc(1'b1, IDX_GAIN_L, 8'h11);
      smp(16'h0010, 16'h0010, 1000);
      acc(1'b1, IDX_GAIN_L, 8'h12);
      smp(16'h0010, 16'h0010, 1048);
      check(32'(left_gain_code), 32'h10);
      rd_chk(IDX_STATUS, 8'h80);
      smp(16'h0010, 16'h0010, 1);
      check(32'(left_gain_code), 32'h12);
      acc(1'b1, IDX_GAIN_L, 8'h13);
      smp(16'h0010, 16'h0010, 1000);
      acc(1'b1, IDX_GAIN_R, 8'h14);
      smp(16'h0010, 16'h0010, 2048);
      check(32'(left_gain_code), 32'h12);
      smp(16'h0010, 16'h0010, 1);
      check(32'(left_gain_code), 32'h13);
      check(32'(right_gain_code), 32'h14);
      acc(1'b1, IDX_CONFIG, 8'h4b);
      acc(1'b1, IDX_GAIN_L, 8'h20);
      acc(1'b1, IDX_LIM_CTRL, 8'h80);
      smp(16'h4000, 16'h4000, 3);
      check(32'(left_gain_code), 32'h20);
      smp(16'hc000, 16'hc000, 1);
      check(32'(right_gain_code), 32'h1f);
      power_down_pin_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rd_chk(IDX_STATUS, 8'h00);
      rd_chk(IDX_PEAK_HI_R, 8'h00);
      rd_chk(IDX_LIM_CTRL, 8'h18);
      $display("zero-cross and power-down test done");
   endtask

   initial begin
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      t_init();
      t_peak();
      t_limit();
      t_zero_cross();
      print_verdict();
   end
endmodule // tb_input_level_monitor_limiter
